// ===== smsc_core.sv
// byte-wide serial port core, master or slave, with register port
`timescale 1ns/1ps
module smsc_core (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic irq,
  input wire smsc_pkg::smsc_pins_t pin_in,
  output smsc_pkg::smsc_pins_t pin_out,
  output smsc_pkg::smsc_pins_t pin_oe
);
  import smsc_pkg::*;

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic [7:0] ctrl1;
  logic [7:0] ctrl2;
  logic [7:0] baud;
  logic [7:0] tx_buf;
  logic [7:0] rx_buf;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [4:0] edge_cnt;
  logic [4:0] edge_num;
  smsc_state_t state;
  logic tx_full;
  logic done_flag;
  logic mode_fault_flag_flag;
  logic txe_seen;
  logic done_seen;
  logic mode_fault_flag_seen;
  logic latched;
  logic sck_lvl;
  logic sck_prev;
  logic tick;
  logic en;
  logic is_master;
  logic clock_phase_bit;
  logic lsbf;
  logic bidirectional_routing_bit;
  logic master_on;
  logic slave_on;
  logic slave_sel;
  logic din;
  logic out_bit;
  logic mode_fault_flag_evt;
  logic cfg_abort;
  logic abort;
  logic load_m;
  logic load_s;
  logic edge_evt;
  logic is_latch;
  logic do_shift;
  logic sh_val;
  logic xfer_done;
  logic wr_data;
  logic rd_data;
  logic wr_ctrl1;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  assign en = ctrl1[CR1_EN];
  assign is_master = ctrl1[CR1_CONTROLLER_SELECT_BIT];
  assign clock_phase_bit = ctrl1[CR1_CLOCK_PHASE_BIT];
  assign lsbf = ctrl1[CR1_LSBF];
  assign bidirectional_routing_bit = ctrl2[CR2_BIDIRECTIONAL_ROUTING_BIT];
  assign master_on = en && is_master;
  assign slave_on = en && !is_master;
  assign slave_sel = slave_on && !pin_in.ss;
  assign wr_data = wr && (addr == OFF_DATA);
  assign rd_data = rd && (addr == OFF_DATA);
  assign wr_ctrl1 = wr && (addr == OFF_CTRL1);

  // select input low while guarded master
  assign mode_fault_flag_evt = master_on && ctrl2[CR2_FAULT_DETECT_ENABLE] && !ctrl1[CR1_SELECT_OUTPUT_ENABLE] && !pin_in.ss;

  always_comb begin
    cfg_abort = 1'b0;
    if (master_on && wr) begin
      case (addr)
        OFF_CTRL1: cfg_abort = |((wdata ^ ctrl1) & CTRL1_ABORT);
        OFF_CTRL2: cfg_abort = |((wdata ^ ctrl2) & CTRL2_ABORT)
                               || (bidirectional_routing_bit && (wdata[CR2_BIDIRECTIONAL_OUTPUT_ENABLE] != ctrl2[CR2_BIDIRECTIONAL_OUTPUT_ENABLE]));
        OFF_BAUD: cfg_abort = |((wdata ^ baud) & BAUD_MASK);
        default: cfg_abort = 1'b0;
      endcase
    end
  end
  assign abort = cfg_abort || mode_fault_flag_evt || !en;

  // ------------------------------------------------------------
  // rate divider
  // ------------------------------------------------------------
  smsc_rate_div u_div (
    .clk(clk),
    .arst_n(arst_n),
    .run(state != ST_IDLE && !abort),
    .presel(baud[6:4]),
    .sel(baud[2:0]),
    .tick(tick)
  );

  // ------------------------------------------------------------
  // shift engine combinational terms
  // ------------------------------------------------------------
  // with routing, each role takes data from its one shared pin: mosi as master, miso as slave
  assign din = is_master ? (bidirectional_routing_bit ? pin_in.mosi : pin_in.miso)
                         : (bidirectional_routing_bit ? pin_in.miso : pin_in.mosi);
  assign out_bit = lsbf ? shreg[0] : shreg[7];
  // the lead-in tick is already the first serial clock edge
  assign edge_evt = (master_on && (state == ST_LEAD || state == ST_XFER) && tick)
                    || (slave_sel && pin_in.sck != sck_prev);
  assign edge_num = edge_cnt + 5'h01;
  assign is_latch = clock_phase_bit ? !edge_num[0] : edge_num[0];
  assign sh_val = (clock_phase_bit && edge_num == EDGES_PER_BYTE) ? din : latched;
  assign do_shift = edge_evt && (is_latch ? (clock_phase_bit && edge_num == EDGES_PER_BYTE)
                                          : !(clock_phase_bit && edge_num == 5'h01));
  assign next_shreg = lsbf ? {sh_val, shreg[7:1]} : {shreg[6:0], sh_val};
  assign xfer_done = edge_evt && edge_num == EDGES_PER_BYTE && !abort;
  assign load_m = master_on && state == ST_IDLE && tx_full && !abort;
  assign load_s = slave_on && pin_in.ss && tx_full;

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl1 <= CTRL1_RST;
      ctrl2 <= CTRL2_RST;
      baud <= BAUD_RST;
    end else begin
      if (wr_ctrl1) begin
        ctrl1 <= wdata & CTRL1_MASK;
      end
      if (mode_fault_flag_evt) begin
        ctrl1[CR1_CONTROLLER_SELECT_BIT] <= 1'b0;
      end
      if (wr && addr == OFF_CTRL2) begin
        ctrl2 <= wdata & CTRL2_MASK;
      end
      if (wr && addr == OFF_BAUD) begin
        baud <= wdata & BAUD_MASK;
      end
    end
  end

  // ------------------------------------------------------------
  // status read tracking
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txe_seen <= 1'b0;
      done_seen <= 1'b0;
      mode_fault_flag_seen <= 1'b0;
    end else if (rd && addr == OFF_STATUS) begin
      txe_seen <= !tx_full;
      done_seen <= done_flag;
      mode_fault_flag_seen <= mode_fault_flag_flag;
    end else begin
      if (wr_data) begin
        txe_seen <= 1'b0;
      end
      if (rd_data) begin
        done_seen <= 1'b0;
      end
      if (wr_ctrl1) begin
        mode_fault_flag_seen <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // transmit buffer
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_buf <= 8'h00;
      tx_full <= 1'b0;
    end else if (wr_data && txe_seen && !tx_full) begin
      tx_buf <= wdata;
      tx_full <= 1'b1;
    end else if (load_m || load_s) begin
      tx_full <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // receive buffer and flags
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_buf <= 8'h00;
      done_flag <= 1'b0;
    end else if (xfer_done && !done_flag) begin
      rx_buf <= next_shreg;
      done_flag <= 1'b1;
    end else if (xfer_done) begin
      done_flag <= 1'b1;
    end else if (rd_data && done_seen) begin
      done_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_fault_flag_flag <= 1'b0;
    end else if (mode_fault_flag_evt) begin
      mode_fault_flag_flag <= 1'b1;
    end else if (wr_ctrl1 && mode_fault_flag_seen) begin
      mode_fault_flag_flag <= 1'b0;
    end
  end

  assign irq = ctrl1[CR1_IE] && (done_flag || mode_fault_flag_flag);

  // ------------------------------------------------------------
  // master sequencer
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      sck_lvl <= 1'b0;
    end else if (abort || !is_master) begin
      state <= ST_IDLE;
      sck_lvl <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (load_m) begin
            state <= ST_LEAD;
          end
        end
        ST_LEAD: begin
          if (tick) begin
            sck_lvl <= !sck_lvl;
            state <= ST_XFER;
          end
        end
        ST_XFER: begin
          if (tick) begin
            sck_lvl <= !sck_lvl;
            if (edge_num == EDGES_PER_BYTE) begin
              state <= ST_TRAIL;
            end
          end
        end
        ST_TRAIL: begin
          if (tick) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // shift register and edge counter
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shreg <= 8'h00;
      latched <= 1'b0;
      edge_cnt <= 5'h00;
      sck_prev <= 1'b0;
    end else begin
      sck_prev <= pin_in.sck;
      if (load_m || load_s) begin
        shreg <= tx_buf;
        edge_cnt <= 5'h00;
      end else if (abort || (slave_on && pin_in.ss) || (master_on && state == ST_IDLE)) begin
        edge_cnt <= 5'h00;
      end else if (edge_evt) begin
        edge_cnt <= (edge_num == EDGES_PER_BYTE) ? 5'h00 : edge_num;
        if (is_latch) begin
          latched <= din;
        end
        if (do_shift) begin
          shreg <= next_shreg;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // register read port
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        OFF_CTRL1: rdata <= ctrl1;
        OFF_CTRL2: rdata <= ctrl2;
        OFF_BAUD: rdata <= baud;
        OFF_STATUS: rdata <= {done_flag, 1'b0, !tx_full, mode_fault_flag_flag, 4'h0};
        OFF_DATA: rdata <= rx_buf;
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // ------------------------------------------------------------
  // pins
  // ------------------------------------------------------------
  always_comb begin
    pin_out.ss = !(master_on && state != ST_IDLE);
    pin_out.sck = sck_lvl ^ ctrl1[CR1_CLOCK_POLARITY_BIT];
    pin_out.mosi = out_bit;
    pin_out.miso = out_bit;
    pin_oe.ss = master_on && ctrl2[CR2_FAULT_DETECT_ENABLE] && ctrl1[CR1_SELECT_OUTPUT_ENABLE];
    pin_oe.sck = master_on;
    pin_oe.mosi = master_on && (!bidirectional_routing_bit || ctrl2[CR2_BIDIRECTIONAL_OUTPUT_ENABLE]);
    // slave data out stays off while a mode fault is pending
    pin_oe.miso = slave_sel && !mode_fault_flag_flag && (!bidirectional_routing_bit || ctrl2[CR2_BIDIRECTIONAL_OUTPUT_ENABLE]);
  end
endmodule

// ===== smsc_pkg.sv
// shared constants and types for the serial port core
package smsc_pkg;
  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL1 = 8'h00;
  localparam logic [7:0] OFF_CTRL2 = 8'h01;
  localparam logic [7:0] OFF_BAUD = 8'h02;
  localparam logic [7:0] OFF_STATUS = 8'h03;
  localparam logic [7:0] OFF_DATA = 8'h05;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CR1_IE = 7;
  localparam int CR1_EN = 6;
  localparam int CR1_CONTROLLER_SELECT_BIT = 4;
  localparam int CR1_CLOCK_POLARITY_BIT = 3;
  localparam int CR1_CLOCK_PHASE_BIT = 2;
  localparam int CR1_SELECT_OUTPUT_ENABLE = 1;
  localparam int CR1_LSBF = 0;
  localparam int CR2_FAULT_DETECT_ENABLE = 4;
  localparam int CR2_BIDIRECTIONAL_OUTPUT_ENABLE = 3;
  localparam int CR2_BIDIRECTIONAL_ROUTING_BIT = 0;
  localparam int SR_DONE = 7;
  localparam int SR_TXE = 5;
  localparam int SR_MODE_FAULT_FLAG = 4;
  // ------------------------------------------------------------
  // reset values and masks
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL1_RST = 8'h04;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [7:0] CTRL1_MASK = 8'hDF;
  localparam logic [7:0] CTRL2_MASK = 8'h19;
  localparam logic [7:0] BAUD_MASK = 8'h77;
  localparam logic [7:0] CTRL1_ABORT = 8'h0F;
  localparam logic [7:0] CTRL2_ABORT = 8'h11;
  // ------------------------------------------------------------
  // transfer counts
  // ------------------------------------------------------------
  localparam logic [4:0] EDGES_PER_BYTE = 5'h10;
  localparam int HALF_W = 11;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LEAD = 2'b01,
    ST_XFER = 2'b10,
    ST_TRAIL = 2'b11
  } smsc_state_t;
  typedef struct packed {
    logic ss;
    logic sck;
    logic mosi;
    logic miso;
  } smsc_pins_t;
endpackage

// ===== smsc_rate_div.sv
// half serial clock period tick generator
`timescale 1ns/1ps
module smsc_rate_div (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic run,
  input wire logic [2:0] presel,
  input wire logic [2:0] sel,
  output logic tick
);
  import smsc_pkg::*;
  logic [HALF_W-1:0] cnt;
  logic [HALF_W-1:0] half;

  // half period = (presel + 1) * 2^sel module clocks
  assign half = HALF_W'({8'h00, presel} + 11'h001) << sel;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= '0;
    end else if (!run || tick) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 11'h001;
    end
  end

  assign tick = run && (cnt == half - 11'h001);
endmodule

// ===== smsc_core_assertions.sv
// concurrent checks on the ports of the serial port core
`timescale 1ns/1ps
module smsc_core_assertions (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic irq,
  input wire smsc_pkg::smsc_pins_t pin_in,
  input wire smsc_pkg::smsc_pins_t pin_out,
  input wire smsc_pkg::smsc_pins_t pin_oe
);
  import smsc_pkg::*;
  logic prev_ss;
  logic prev_sck;
  logic quiet;
  logic ie_sh;
  logic fault_detect_enable_sh;
  logic [7:0] baud_sh;
  logic [11:0] cnt;
  logic [4:0] nedge;
  logic [11:0] half;
  logic sck_ev;
  logic ev;
  assign sck_ev = pin_out.sck != prev_sck;
  assign ev = sck_ev || (pin_out.ss != prev_ss);
  assign half = (12'h001 + {9'h000, baud_sh[6:4]}) << baud_sh[2:0];
  // ------------------------------------------------------------
  // shadows of written fields and frame timing
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_ss <= 1'b1;
      prev_sck <= 1'b0;
      quiet <= 1'b0;
      ie_sh <= 1'b0;
      fault_detect_enable_sh <= 1'b0;
      baud_sh <= 8'h00;
      cnt <= 12'h000;
      nedge <= 5'h00;
    end else begin
      prev_ss <= pin_out.ss;
      prev_sck <= pin_out.sck;
      cnt <= ev ? 12'h001 : cnt + 12'h001;
      if (wr && addr inside {OFF_CTRL1, OFF_CTRL2, OFF_BAUD}) begin
        quiet <= 1'b0;
      end else if (prev_ss && !pin_out.ss) begin
        quiet <= 1'b1;
      end
      if (prev_ss && !pin_out.ss) begin
        nedge <= 5'h00;
      end else if (sck_ev && !prev_ss) begin
        nedge <= nedge + 5'h01;
      end
      if (wr && addr == OFF_BAUD) begin
        baud_sh <= wdata;
      end
      if (wr && addr == OFF_CTRL1) begin
        ie_sh <= wdata[CR1_IE];
      end
      if (wr && addr == OFF_CTRL2) begin
        fault_detect_enable_sh <= wdata[CR2_FAULT_DETECT_ENABLE];
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  half_period_a: assert property (
    ev && !prev_ss && pin_oe.ss && pin_oe.sck && quiet |-> cnt == half)
    else $error("serial clock spacing wrong");
  clock_in_frame_a: assert property (
    sck_ev && pin_oe.ss && pin_oe.sck && quiet |-> !prev_ss)
    else $error("serial clock moved outside a frame");
  edge_count_a: assert property (
    pin_out.ss && !prev_ss && pin_oe.ss && quiet |-> nedge == 5'd16)
    else $error("frame did not carry sixteen edges");
  slave_float_a: assert property (
    pin_in.ss && $past(pin_in.ss) && $past(pin_in.ss, 2) |-> !pin_oe.miso)
    else $error("deselected slave drives data");
  one_driver_a: assert property (
    pin_oe.miso |-> !pin_oe.mosi && !pin_oe.sck && !pin_oe.ss)
    else $error("slave data out beside master outputs");
  fault_abort_a: assert property (
    fault_detect_enable_sh && pin_oe.sck && !pin_oe.ss && !pin_in.ss
    |-> ##[1:4] !pin_oe.sck && !pin_oe.mosi && !pin_oe.miso)
    else $error("mode fault left outputs on");
  irq_mask_a: assert property (!ie_sh |-> !irq)
    else $error("interrupt while disabled");
  read_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside answer cycle");
endmodule
bind smsc_core smsc_core_assertions chk (.clk(clk), .arst_n(arst_n), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe(pin_oe));

// ===== smsc_remote.sv
// remote serial peripheral facing the core in master role
`timescale 1ns/1ps
module smsc_remote (
  input wire logic sel_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic clock_polarity_bit,
  input wire logic clock_phase_bit,
  input wire logic [7:0] tx,
  output logic miso,
  output logic [7:0] rx
);
  logic [7:0] sh;
  initial begin
    miso = 1'b0;
    rx = 8'h00;
    sh = 8'h00;
  end
  always @(negedge sel_n) begin
    sh = tx;
    if (!clock_phase_bit) miso = sh[7];
  end
  // released line must not keep its last bit
  always @(posedge sel_n) miso = ~miso;
  always @(sck) begin
    if (!sel_n) begin
      if ((sck ^ clock_polarity_bit) ^ clock_phase_bit) begin
        rx = {rx[6:0], mosi};
      end else if (clock_phase_bit) begin
        miso = sh[7];
        sh = sh << 1;
      end else begin
        sh = sh << 1;
        miso = sh[7];
      end
    end
  end
endmodule

// ===== testbench.sv
// self-checking bench for the serial port core
`timescale 1ns/1ps
module testbench;
  import smsc_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic irq;
  logic tb_ss = 1'b1;
  logic tb_sck = 1'b0;
  logic tb_mosi = 1'b0;
  logic rem_miso;
  logic rem_mosi = 1'b0;
  logic clock_polarity_bit = 1'b0;
  logic clock_phase_bit = 1'b0;
  logic [7:0] rem_tx = 8'h00;
  logic [7:0] rem_rx;
  logic [7:0] s;
  logic [7:0] ra [5] = '{OFF_CTRL1, OFF_CTRL2, OFF_BAUD, OFF_STATUS, 8'h04};
  logic [7:0] rv [5] = '{CTRL1_RST, CTRL2_RST, BAUD_RST, 8'h20, 8'h00};
  int n_errors = 0;
  int num_checks = 0;
  smsc_pins_t pin_in;
  smsc_pins_t pin_out;
  smsc_pins_t pin_oe;
  always #5 clk = ~clk;
  // remote sees master data as it stood before the clock edge
  always @(negedge clk) rem_mosi <= pin_in.mosi;
  assign pin_in = {pin_oe.ss ? pin_out.ss : tb_ss, pin_oe.sck ? pin_out.sck : tb_sck,
    pin_oe.mosi ? pin_out.mosi : tb_mosi, pin_oe.miso ? pin_out.miso : rem_miso};
  smsc_core uut (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .irq(irq), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
  smsc_remote rem (.sel_n(pin_in.ss), .sck(pin_in.sck), .mosi(rem_mosi), .clock_polarity_bit(clock_polarity_bit),
    .clock_phase_bit(clock_phase_bit), .tx(rem_tx), .miso(rem_miso), .rx(rem_rx));
  // ------------------------------------------------------------
  // bus, compare and expectation helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic rst;
    arst_n <= 1'b0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic wlv(input logic v);
    int k;
    k = 0;
    while (pin_out.ss !== v && k < 400) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk({7'h00, k < 400}, 8'h01);
  endtask
  function automatic logic [7:0] ord(input logic [7:0] v, input logic lsbf);
    ord = v;
    for (int i = 0; i < 8; i++) begin
      if (lsbf) ord[i] = v[7 - i];
    end
  endfunction
  task automatic mx(input logic [7:0] c1, input logic [7:0] b, input logic [7:0] t,
    input logic [7:0] p);
    clock_polarity_bit = c1[CR1_CLOCK_POLARITY_BIT];
    clock_phase_bit = c1[CR1_CLOCK_PHASE_BIT];
    rem_tx = p;
    wreg(OFF_BAUD, b);
    wreg(OFF_CTRL1, 8'h52 | c1);
    rreg(OFF_STATUS, s);
    chk(s & 8'hB0, 8'h20);
    wreg(OFF_DATA, t);
    wlv(1'b0);
    wlv(1'b1);
    rreg(OFF_STATUS, s);
    chk(s & 8'hB0, 8'hA0);
    rreg(OFF_DATA, s);
    chk(s, ord(p, c1[CR1_LSBF]));
    chk(rem_rx, ord(t, c1[CR1_LSBF]));
    rreg(OFF_STATUS, s);
    chk(s & 8'h80, 8'h00);
  endtask
  task automatic sx(input logic ph, input logic [7:0] d, input logic [7:0] m);
    logic [7:0] r;
    logic [7:0] sh;
    sh = m;
    r = 8'h00;
    wreg(OFF_CTRL1, {5'b01000, ph, 2'b00});
    rreg(OFF_STATUS, s);
    wreg(OFF_DATA, d);
    repeat (4) begin
      @(posedge clk);
      tb_sck <= ~tb_sck;
    end
    @(posedge clk);
    tb_ss <= 1'b0;
    tb_mosi <= sh[7];
    for (int e = 1; e <= 16; e++) begin
      repeat (7) @(posedge clk);
      #1;
      if (e[0] ^ ph) r = {r[6:0], pin_in.miso};
      @(posedge clk);
      tb_sck <= ~tb_sck;
      if (!(e[0] ^ ph) && !(ph && e == 1)) begin
        sh = sh << 1;
        tb_mosi <= sh[7];
      end
    end
    repeat (8) @(posedge clk);
    tb_ss <= 1'b1;
    tb_mosi <= ~tb_mosi;
    chk(r, d);
    rreg(OFF_STATUS, s);
    chk(s & 8'h80, 8'h80);
    rreg(OFF_DATA, s);
    chk(s, m);
  endtask
  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (50000) @(posedge clk);
    n_errors++;
    $display("wrong value at %0t: run hung", $time);
    end_sim;
  end
  initial begin
    void'($urandom(63));
    rst;
    for (int i = 0; i < 5; i++) begin
      rreg(ra[i], s);
      chk(s, rv[i]);
    end
    rst;
    wreg(OFF_CTRL2, 8'h10);
    wreg(OFF_CTRL1, 8'h52);
    wreg(OFF_DATA, 8'h99);
    repeat (30) @(posedge clk);
    rreg(OFF_STATUS, s);
    chk(s & 8'hA0, 8'h20);
    for (int m = 0; m < 4; m++) begin
      mx({4'h0, m[1], m[0], 2'b00}, 8'h00, 8'hC5 ^ 8'(m), 8'h3A + 8'(m));
    end
    for (int i = 0; i < 8; i++) begin
      mx(8'($urandom) & 8'h0D, 8'($urandom) & 8'h13, 8'($urandom), 8'($urandom));
    end
    clock_polarity_bit = 1'b0;
    clock_phase_bit = 1'b0;
    rem_tx = 8'h3C;
    wreg(OFF_BAUD, 8'h00);
    wreg(OFF_CTRL1, 8'h52);
    rreg(OFF_STATUS, s);
    wreg(OFF_DATA, 8'hA5);
    wlv(1'b0);
    rem_tx = 8'hC3;
    rreg(OFF_STATUS, s);
    wreg(OFF_DATA, 8'h5A);
    wlv(1'b1);
    wlv(1'b0);
    wlv(1'b1);
    rreg(OFF_STATUS, s);
    rreg(OFF_DATA, s);
    chk(s, 8'h3C);
    chk(rem_rx, 8'h5A);
    wreg(OFF_BAUD, 8'h13);
    rreg(OFF_STATUS, s);
    wreg(OFF_DATA, 8'h66);
    wlv(1'b0);
    repeat (40) @(posedge clk);
    wreg(OFF_CTRL1, 8'h56);
    wlv(1'b1);
    rreg(OFF_STATUS, s);
    chk(s & 8'h80, 8'h00);
    wreg(OFF_CTRL1, 8'hD0);
    @(posedge clk);
    tb_ss <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk({4'h0, pin_oe.miso, pin_oe.mosi, irq, pin_oe.sck}, 8'h02);
    rreg(OFF_STATUS, s);
    chk(s & 8'h10, 8'h10);
    rreg(OFF_CTRL1, s);
    chk(s & 8'h10, 8'h00);
    @(posedge clk);
    tb_ss <= 1'b1;
    wreg(OFF_CTRL1, 8'hC0);
    rreg(OFF_STATUS, s);
    chk({s[4], 6'h00, irq}, 8'h00);
    sx(1'b0, 8'hB4, 8'h2D);
    sx(1'b1, 8'h4B, 8'hD2);
    end_sim;
  end
endmodule
